// ---- verilog/mac_address_hash_filter_regs.sv ----
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "mac_filter_map.svh"
module mac_address_hash_filter_regs
    import mac_filter_pkg::*;
(
    input  wire logic                          CLK_IN,
    input  wire logic                          RST_N_IN,
    // AXI4-Lite slave
    input  wire logic      [7:0]               S_AXI_AWADDR_IN,
    input  wire logic                          S_AXI_AWVALID_IN,
    output logic                               S_AXI_AWREADY_OUT,
    input  wire logic      [31:0]              S_AXI_WDATA_IN,
    input  wire logic      [3:0]               S_AXI_WSTRB_IN,
    input  wire logic                          S_AXI_WVALID_IN,
    output logic                               S_AXI_WREADY_OUT,
    output logic      [1:0]                    S_AXI_BRESP_OUT,
    output logic                               S_AXI_BVALID_OUT,
    input  wire logic                          S_AXI_BREADY_IN,
    input  wire logic      [7:0]               S_AXI_ARADDR_IN,
    input  wire logic                          S_AXI_ARVALID_IN,
    output logic                               S_AXI_ARREADY_OUT,
    output logic      [31:0]                   S_AXI_RDATA_OUT,
    output logic      [1:0]                    S_AXI_RRESP_OUT,
    output logic                               S_AXI_RVALID_OUT,
    input  wire logic                          S_AXI_RREADY_IN,
    // EEPROM controller side
    input  wire logic                          EE_PRESENT_IN,
    output mac_filter_pkg::ee_req_type         EE_REQ_OUT,
    input  wire mac_filter_pkg::ee_rsp_type    EE_RSP_IN,
    // Receive filter side
    input  wire mac_filter_pkg::frame_dst_type RX_DST_IN,
    output logic                               RX_DECIDED_OUT,
    output logic                               RX_ACCEPT_OUT,
    output logic                               RX_IS_MCAST_OUT,
    output logic      [47:0]                   STATION_ADDR_OUT,
    output logic      [47:0]                   STATION_WIRE_OUT
);
    // ======================================================================
    // Storage
    logic [31:0] station_address_high_ff, nxt_station_address_high;
    logic [31:0] station_address_low_ff,  nxt_station_address_low;
    logic [31:0] multicast_table_upper_ff, nxt_multicast_table_upper;
    logic [31:0] multicast_table_lower_ff, nxt_multicast_table_lower;
    logic        pass_all_multicast_ff,   nxt_pass_all_multicast;

    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    function automatic logic [5:0] word_index(input logic [7:0] byte_addr);
        return byte_addr[7:2];
    endfunction : word_index

    // ======================================================================
    // EEPROM preload
    logic       ld_wr;
    logic [7:0] ld_addr;
    logic [7:0] ld_data;
    logic       init_done;

    mac_eeprom_loader u_loader (
        .clk_in           (CLK_IN),
        .rst_n_in         (RST_N_IN),
        .ee_present_in    (EE_PRESENT_IN),
        .ee_req_out       (EE_REQ_OUT),
        .ee_rsp_in        (EE_RSP_IN),
        .wr_out           (ld_wr),
        .wr_byte_addr_out (ld_addr),
        .wr_data_out      (ld_data),
        .done_out         (init_done)
    );

    // Byte lanes for the loader: 0x01..0x04 go low, 0x05..0x06 go high
    wire        ld_high  = (ld_addr >= `EE_HIGH_FIRST);
    wire [7:0]  ld_off   = ld_high ? (ld_addr - `EE_HIGH_FIRST) : (ld_addr - `EE_FIRST_BYTE);
    wire [3:0]  ld_strb  = 4'h1 << ld_off[1:0];
    wire [31:0] ld_word  = {4{ld_data}};

    // ======================================================================
    // AXI4-Lite write channel
    logic        aw_held_ff, nxt_aw_held;
    logic        w_held_ff,  nxt_w_held;
    logic [7:0]  aw_addr_ff, nxt_aw_addr;
    logic [31:0] w_data_ff,  nxt_w_data;
    logic [3:0]  w_strb_ff,  nxt_w_strb;
    logic        bvalid_ff,  nxt_bvalid;
    logic [1:0]  bresp_ff,   nxt_bresp;

    assign S_AXI_AWREADY_OUT = !aw_held_ff && !bvalid_ff;
    assign S_AXI_WREADY_OUT  = !w_held_ff && !bvalid_ff;
    wire aw_fire = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
    wire w_fire  = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;

    wire        wr_go  = aw_held_ff && w_held_ff;
    assign nxt_aw_held = (aw_held_ff || aw_fire) && !wr_go;
    assign nxt_w_held  = (w_held_ff || w_fire) && !wr_go;
    assign nxt_aw_addr = aw_fire ? S_AXI_AWADDR_IN : aw_addr_ff;
    assign nxt_w_data  = w_fire ? S_AXI_WDATA_IN : w_data_ff;
    assign nxt_w_strb  = w_fire ? S_AXI_WSTRB_IN : w_strb_ff;

    wire [5:0]  wr_idx = word_index(aw_addr_ff);
    // Address writes refused until init so the load cannot be torn
    wire        wr_ok  = init_done;
    wire        hit_ah = wr_go && wr_ok && (wr_idx == `REG_IDX_ADDR_HIGH);
    wire        hit_al = wr_go && wr_ok && (wr_idx == `REG_IDX_ADDR_LOW);
    wire        hit_tu = wr_go && (wr_idx == `REG_IDX_TABLE_UPPER);
    wire        hit_tl = wr_go && (wr_idx == `REG_IDX_TABLE_LOWER);
    wire        hit_ct = wr_go && (wr_idx == `REG_IDX_CONTROL);
    wire        wr_map = hit_ah || hit_al || hit_tu || hit_tl || hit_ct;

    assign nxt_bvalid = wr_go || (bvalid_ff && !S_AXI_BREADY_IN);
    assign nxt_bresp  = wr_go ? (wr_map ? `RESP_OKAY : `RESP_SLVERR) : bresp_ff;
    assign S_AXI_BVALID_OUT = bvalid_ff;
    assign S_AXI_BRESP_OUT  = bresp_ff;

    // ======================================================================
    // Register updates
    assign nxt_station_address_high =
        (ld_wr && ld_high)  ? apply_strb(station_address_high_ff, ld_word, ld_strb)
                                  & `ADDR_HIGH_MASK :
        hit_ah              ? apply_strb(station_address_high_ff, w_data_ff, w_strb_ff)
                                  & `ADDR_HIGH_MASK :
                              station_address_high_ff;
    assign nxt_station_address_low =
        (ld_wr && !ld_high) ? apply_strb(station_address_low_ff, ld_word, ld_strb) :
        hit_al              ? apply_strb(station_address_low_ff, w_data_ff, w_strb_ff) :
                              station_address_low_ff;
    assign nxt_multicast_table_upper = hit_tu ?
        apply_strb(multicast_table_upper_ff, w_data_ff, w_strb_ff) : multicast_table_upper_ff;
    assign nxt_multicast_table_lower = hit_tl ?
        apply_strb(multicast_table_lower_ff, w_data_ff, w_strb_ff) : multicast_table_lower_ff;
    assign nxt_pass_all_multicast = (hit_ct && w_strb_ff[0]) ?
        w_data_ff[`CTL_PASS_ALL_BIT] : pass_all_multicast_ff;

    // ======================================================================
    // AXI4-Lite read channel
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff,  nxt_rdata;
    logic [1:0]  rresp_ff,  nxt_rresp;

    assign S_AXI_ARREADY_OUT = !rvalid_ff;
    wire        ar_fire = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
    wire [5:0]  rd_idx  = word_index(S_AXI_ARADDR_IN);
    wire [31:0] ctl_rd  = ({31'h0, pass_all_multicast_ff} << `CTL_PASS_ALL_BIT) |
                          ({31'h0, init_done} << `CTL_INIT_DONE_BIT);
    wire        rd_map  = (rd_idx == `REG_IDX_ADDR_HIGH) || (rd_idx == `REG_IDX_ADDR_LOW) ||
                          (rd_idx == `REG_IDX_TABLE_UPPER) || (rd_idx == `REG_IDX_TABLE_LOWER) ||
                          (rd_idx == `REG_IDX_CONTROL);
    wire [31:0] rd_mux  =
        (rd_idx == `REG_IDX_ADDR_HIGH)   ? (station_address_high_ff & `ADDR_HIGH_MASK) :
        (rd_idx == `REG_IDX_ADDR_LOW)    ? station_address_low_ff :
        (rd_idx == `REG_IDX_TABLE_UPPER) ? multicast_table_upper_ff :
        (rd_idx == `REG_IDX_TABLE_LOWER) ? multicast_table_lower_ff :
        (rd_idx == `REG_IDX_CONTROL)     ? ctl_rd : 32'h00000000;

    assign nxt_rvalid = ar_fire || (rvalid_ff && !S_AXI_RREADY_IN);
    assign nxt_rdata  = ar_fire ? rd_mux : rdata_ff;
    assign nxt_rresp  = ar_fire ? (rd_map ? `RESP_OKAY : `RESP_SLVERR) : rresp_ff;
    assign S_AXI_RVALID_OUT = rvalid_ff;
    assign S_AXI_RDATA_OUT  = rdata_ff;
    assign S_AXI_RRESP_OUT  = rresp_ff;

    // ======================================================================
    // Address presentation
    wire [47:0] station = {station_address_high_ff[15:0], station_address_low_ff};
    // Octet n sits at bits 8n-1:8n-8, octet one (most significant written) first
    assign STATION_ADDR_OUT = station;

    // ======================================================================
    // Multicast filter
    logic [5:0] hash_idx;
    mac_hash_index u_hash (
        .dest_in   (RX_DST_IN.dest),
        .index_out (hash_idx)
    );
    wire        hash_bit  = hash_idx[5] ? multicast_table_upper_ff[hash_idx[4:0]]
                                        : multicast_table_lower_ff[hash_idx[4:0]];
    // Group bit is the LSB of octet one, the first bit on the wire
    wire        is_mcast  = RX_DST_IN.dest[0];
    wire        unicast_hit = (RX_DST_IN.dest == station);
    wire        accept    = is_mcast ? (pass_all_multicast_ff || hash_bit)
                                     : unicast_hit;

    logic        decided_ff, accept_ff, mcast_ff;
    logic [47:0] wire_ff;

    // ======================================================================
    // Flops
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            station_address_high_ff  <= `RST_ADDR_HIGH;
            station_address_low_ff   <= `RST_ADDR_LOW;
            multicast_table_upper_ff <= `RST_TABLE;
            multicast_table_lower_ff <= `RST_TABLE;
            pass_all_multicast_ff    <= 1'b0;
        end else begin
            station_address_high_ff  <= nxt_station_address_high;
            station_address_low_ff   <= nxt_station_address_low;
            multicast_table_upper_ff <= nxt_multicast_table_upper;
            multicast_table_lower_ff <= nxt_multicast_table_lower;
            pass_all_multicast_ff    <= nxt_pass_all_multicast;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            rvalid_ff  <= 1'b0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            bvalid_ff  <= nxt_bvalid;
            rvalid_ff  <= nxt_rvalid;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h00000000;
            w_strb_ff  <= 4'h0;
            bresp_ff   <= `RESP_OKAY;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= `RESP_OKAY;
        end else begin
            aw_addr_ff <= nxt_aw_addr;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            bresp_ff   <= nxt_bresp;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            decided_ff <= 1'b0;
            accept_ff  <= 1'b0;
            mcast_ff   <= 1'b0;
            wire_ff    <= 48'h000000000000;
        end else begin
            decided_ff <= RX_DST_IN.valid;
            accept_ff  <= RX_DST_IN.valid && accept;
            mcast_ff   <= RX_DST_IN.valid && is_mcast;
            wire_ff    <= station;
        end
    end

    assign RX_DECIDED_OUT   = decided_ff;
    assign RX_ACCEPT_OUT    = accept_ff;
    assign RX_IS_MCAST_OUT  = mcast_ff;
    assign STATION_WIRE_OUT = wire_ff;
endmodule : mac_address_hash_filter_regs
`default_nettype wire

// ---- include/mac_filter_map.svh ----
// Behaviour
// - Address-high holds address bits 47:32 in bits 15:0; bits 31:16 read zero.
// - Address-low holds address bits 31:0 in all 32 bits.
// - At power-on load both address registers from EEPROM only if programmed.
// - EEPROM byte 0x05 to high bits 7:0, byte 0x06 to high 15:8.
// - EEPROM bytes 0x01..0x04 fill low bytes ascending, 0x01 into bits 7:0.
// - Wire octet one is low bits 7:0, octets five and six from high register.
// - Most significant written octet is sent and received first on the medium.
// - Address undefined until load ends; host writes only after initialization.
// - Six-bit hash index; top bit picks table register, five bits pick bit.
// - Index zero selects low table bit 0; all ones selects high bit 31.
// - Accept multicast when selected table bit is one, reject when zero.
// - Pass-all-multicast set accepts every multicast, ignoring the table.
// - Upper table register holds bits 63:32, lower bits 31:0, both read/write.
`ifndef MAC_FILTER_MAP_SVH
`define MAC_FILTER_MAP_SVH
// ==========================================================================
// Register map (printed offsets are word indices)
`define REG_IDX_ADDR_HIGH   6'h02
`define REG_IDX_ADDR_LOW    6'h03
`define REG_IDX_TABLE_UPPER 6'h04
`define REG_IDX_TABLE_LOWER 6'h05
`define REG_IDX_CONTROL     6'h09
`define RST_ADDR_HIGH       32'h00000FFF
`define RST_ADDR_LOW        32'h0FFFFFFF
`define RST_TABLE           32'h00000000
`define ADDR_HIGH_MASK      32'h0000FFFF
// Control register fields
`define CTL_PASS_ALL_BIT    0
`define CTL_INIT_DONE_BIT   8
// EEPROM byte addresses
`define EE_FIRST_BYTE       8'h01
`define EE_LAST_BYTE        8'h06
`define EE_HIGH_FIRST       8'h05
// CRC and AXI response codes
`define CRC_INIT            32'hFFFFFFFF
`define CRC_POLY            32'hEDB88320
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`endif

// ---- include/mac_filter_pkg.sv ----
package mac_filter_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic       valid;
    } ee_req_type;
    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } ee_rsp_type;
    typedef struct packed {
        logic [47:0] dest;
        logic        valid;
    } frame_dst_type;
    typedef enum logic [1:0] {
        LOAD_IDLE = 2'b00,
        LOAD_REQ  = 2'b01,
        LOAD_WAIT = 2'b10,
        LOAD_DONE = 2'b11
    } load_state_type;
endpackage : mac_filter_pkg

// ---- verilog/mac_hash_index.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mac_filter_map.svh"
module mac_hash_index (
    input  wire logic [47:0] dest_in,
    output logic      [5:0]  index_out
);
    // Reflected CRC-32, octet one first, LSB first on the wire
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    logic [31:0] crc_chain [0:6];
    assign crc_chain[0] = `CRC_INIT;
    for (genvar g = 0; g < 6; g++) begin : g_oct
        assign crc_chain[g+1] = crc_byte(crc_chain[g], dest_in[g*8 +: 8]);
    end
    // Low six bits of the final reflected CRC, bit order reversed
    wire [31:0] crc_fin = ~crc_chain[6];
    assign index_out = {crc_fin[0], crc_fin[1], crc_fin[2],
                        crc_fin[3], crc_fin[4], crc_fin[5]};
endmodule : mac_hash_index
`default_nettype wire

// ---- verilog/mac_eeprom_loader.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mac_filter_map.svh"
module mac_eeprom_loader
    import mac_filter_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       ee_present_in,
    output mac_filter_pkg::ee_req_type      ee_req_out,
    input  wire mac_filter_pkg::ee_rsp_type ee_rsp_in,
    output logic                            wr_out,
    output logic      [7:0]                 wr_byte_addr_out,
    output logic      [7:0]                 wr_data_out,
    output logic                            done_out
);
    load_state_type state_ff, nxt_state;
    logic [7:0]     addr_ff,  nxt_addr;

    wire last = (addr_ff == `EE_LAST_BYTE);
    always_comb begin
        nxt_state = state_ff;
        nxt_addr  = addr_ff;
        unique case (state_ff)
            LOAD_IDLE: nxt_state = ee_present_in ? LOAD_REQ : LOAD_DONE;
            LOAD_REQ:  nxt_state = LOAD_WAIT;
            LOAD_WAIT: if (ee_rsp_in.valid) begin
                nxt_state = last ? LOAD_DONE : LOAD_REQ;
                nxt_addr  = addr_ff + 8'h01;
            end
            LOAD_DONE: nxt_state = LOAD_DONE;
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= LOAD_IDLE;
            addr_ff  <= `EE_FIRST_BYTE;
        end else begin
            state_ff <= nxt_state;
            addr_ff  <= nxt_addr;
        end
    end
    assign ee_req_out.valid  = (state_ff == LOAD_REQ);
    assign ee_req_out.addr   = addr_ff;
    assign wr_out            = (state_ff == LOAD_WAIT) && ee_rsp_in.valid;
    assign wr_byte_addr_out  = addr_ff;
    assign wr_data_out       = ee_rsp_in.data;
    assign done_out          = (state_ff == LOAD_DONE);
endmodule : mac_eeprom_loader
`default_nettype wire

// ---- verif/mac_filter_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Port checker
module mac_filter_asserts
    import mac_filter_pkg::*;
(
    input wire logic                          CLK_IN,
    input wire logic                          RST_N_IN,
    input wire logic      [7:0]               S_AXI_ARADDR_IN,
    input wire logic                          S_AXI_ARVALID_IN,
    input wire logic                          S_AXI_ARREADY_OUT,
    input wire logic      [31:0]              S_AXI_RDATA_OUT,
    input wire logic                          S_AXI_RVALID_OUT,
    input wire logic                          S_AXI_RREADY_IN,
    input wire logic                          S_AXI_AWREADY_OUT,
    input wire logic                          S_AXI_WREADY_OUT,
    input wire logic      [1:0]               S_AXI_BRESP_OUT,
    input wire logic                          S_AXI_BVALID_OUT,
    input wire logic                          S_AXI_BREADY_IN,
    input wire mac_filter_pkg::ee_req_type    EE_REQ_OUT,
    input wire mac_filter_pkg::frame_dst_type RX_DST_IN,
    input wire logic                          RX_DECIDED_OUT,
    input wire logic                          RX_ACCEPT_OUT,
    input wire logic                          RX_IS_MCAST_OUT,
    input wire logic      [47:0]              STATION_ADDR_OUT,
    input wire logic      [47:0]              STATION_WIRE_OUT
);
    logic [7:0] last_ee_ff;
    logic [7:0] rd_addr_ff;
    // Read address kept for the data checks
    always_ff @(posedge CLK_IN) begin
        last_ee_ff <= !RST_N_IN ? 8'h00 : EE_REQ_OUT.valid ? EE_REQ_OUT.addr : last_ee_ff;
        rd_addr_ff <= !RST_N_IN ? 8'h00 :
            (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) ? S_AXI_ARADDR_IN : rd_addr_ff;
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ======================================================================
    // Assertions
    chk_ee_order: assert property (EE_REQ_OUT.valid |->
        EE_REQ_OUT.addr == last_ee_ff + 8'h01 && EE_REQ_OUT.addr <= 8'h06)
        else $error("EEPROM byte requested out of order");
    chk_high_rsvd: assert property (S_AXI_RVALID_OUT && rd_addr_ff == 8'h08 |->
        S_AXI_RDATA_OUT == {16'h0000, STATION_ADDR_OUT[47:32]}) else $error("High word wrong");
    chk_low_word: assert property (S_AXI_RVALID_OUT && rd_addr_ff == 8'h0C |->
        S_AXI_RDATA_OUT == STATION_ADDR_OUT[31:0]) else $error("Low word wrong");
    chk_read_answer: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
        else $error("Read answer late");
    chk_r_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
        S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("Read data dropped");
    chk_b_blocks: assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
        else $error("Write taken during response");
    chk_b_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
        S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("Write response dropped");
    chk_rx_decide: assert property (RX_DST_IN.valid |=> RX_DECIDED_OUT &&
        RX_IS_MCAST_OUT == $past(RX_DST_IN.dest[0])) else $error("No filter decision");
    chk_rx_idle: assert property (!RX_DST_IN.valid |=> !RX_DECIDED_OUT)
        else $error("Decision without frame");
    chk_unicast_match: assert property (RX_DST_IN.valid && !RX_DST_IN.dest[0] |=>
        RX_ACCEPT_OUT == ($past(RX_DST_IN.dest) == $past(STATION_ADDR_OUT)))
        else $error("Unicast decision wrong");
    chk_wire_copy: assert property ($past(RST_N_IN) |->
        STATION_WIRE_OUT == $past(STATION_ADDR_OUT)) else $error("Wire address lags wrong");
    cover property (RX_DECIDED_OUT && RX_IS_MCAST_OUT && RX_ACCEPT_OUT);
    cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == 2'b10);
    cover property (EE_REQ_OUT.valid && EE_REQ_OUT.addr == 8'h06);
endmodule : mac_filter_asserts
bind mac_address_hash_filter_regs mac_filter_asserts u_mac_filter_asserts (
    .CLK_IN, .RST_N_IN, .S_AXI_ARADDR_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT,
    .S_AXI_RDATA_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .S_AXI_AWREADY_OUT,
    .S_AXI_WREADY_OUT, .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN,
    .EE_REQ_OUT, .RX_DST_IN, .RX_DECIDED_OUT, .RX_ACCEPT_OUT, .RX_IS_MCAST_OUT,
    .STATION_ADDR_OUT, .STATION_WIRE_OUT);
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mac_filter_map.svh"
module tb;
    import mac_filter_pkg::*;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ee_present, ee_en, ee_pend;
    logic awready, wready, bvalid, arready, rvalid, decided, accept, is_mcast;
    logic [7:0] awaddr, araddr, ee_addr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    logic [47:0] station, cand [3];
    logic [63:0] one;
    ee_req_type ee_req;
    ee_rsp_type ee_rsp;
    frame_dst_type rx_dst;
    int num_errors, cmp_count, cycles, n;
    wire ee_go = ee_pend && ee_en && !ee_rsp.valid;
    mac_address_hash_filter_regs u_mac_address_hash_filter_regs (
        .CLK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
        .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
        .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
        .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
        .EE_PRESENT_IN(ee_present), .EE_REQ_OUT(ee_req), .EE_RSP_IN(ee_rsp), .RX_DST_IN(rx_dst),
        .RX_DECIDED_OUT(decided), .RX_ACCEPT_OUT(accept), .RX_IS_MCAST_OUT(is_mcast),
        .STATION_ADDR_OUT(station), .STATION_WIRE_OUT());
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ======================================================================
    // EEPROM stand-in: byte n holds n*16, scrambled when not valid
    always @(posedge clk) begin
        if (ee_req.valid) ee_addr <= ee_req.addr;
        ee_pend <= rst_n && (ee_req.valid || (ee_pend && !ee_go));
        ee_rsp <= '{data: ee_go ? {ee_addr[3:0], 4'h0} : ~{ee_addr[3:0], 4'h0}, valid: ee_go};
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    // ======================================================================
    // Bus and filter tasks
    task summarize;
        $display("Checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task do_reset(input logic present);
        @(posedge clk);
        rst_n <= 1'b0;
        ee_present <= present;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", e, bresp);
        bready <= 1'b0;
    endtask : wr_chk
    task rd_raw(input logic [7:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata; rr = rresp; rready <= 1'b0;
    endtask : rd_raw
    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] e);
        rd_raw(a);
        chk("rdata", exp, rd);
        chk("rresp", e, rr);
    endtask : rd_chk
    task rx_chk(input logic [47:0] d, input logic exp);
        @(posedge clk);
        rx_dst <= '{dest: d, valid: 1'b1};
        @(posedge clk);
        rx_dst <= '{dest: ~d, valid: 1'b0};
        #1;
        chk("decided", 1'b1, decided);
        chk("accept", exp, accept);
    endtask : rx_chk
    function automatic logic [5:0] hidx(input logic [47:0] d);
        logic [31:0] c;
        logic [5:0]  x;
        c = `CRC_INIT;
        for (int i = 0; i < 48; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? `CRC_POLY : 32'h0);
        c = ~c;
        for (int i = 0; i < 6; i++) x[5 - i] = c[i];
        return x;
    endfunction : hidx
    // ======================================================================
    // Main sequence
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, ee_present, ee_en, ee_pend} = '0;
        {awaddr, araddr, ee_addr, wdata, wstrb} = '0;
        ee_rsp = '0; rx_dst = '0; cand[0] = '0; cand[1] = '0; cand[2] = 48'h0A0B0C0D0E0F;
        do_reset(1'b0);
        rd_chk(8'h08, 32'h00000FFF, 2'b00);
        rd_chk(8'h0C, 32'h0FFFFFFF, 2'b00);
        rd_chk(8'h10, 32'h00000000, 2'b00);
        rd_chk(8'h14, 32'h00000000, 2'b00);
        rd_chk(8'h00, 32'h00000000, 2'b10);
        wr_chk(8'h08, 32'hFFFFABCD, 4'hF, 2'b00);
        rd_chk(8'h08, 32'h0000ABCD, 2'b00);
        wr_chk(8'h0C, 32'h9ABCDEF0, 4'h5, 2'b00);
        rd_chk(8'h0C, 32'h0FBCFFF0, 2'b00);
        wr_chk(8'h18, 32'h12345678, 4'hF, 2'b10);
        chk("station", 48'hABCD0FBCFFF0, station);
        $display("Test absent_eeprom done");
        do_reset(1'b1);
        rd_chk(8'h24, 32'h00000000, 2'b00);
        wr_chk(8'h0C, 32'h11111111, 4'hF, 2'b10);
        ee_en <= 1'b1;
        n = 0;
        do begin
            rd_raw(8'h24);
            n++;
        end while (rd[8] !== 1'b1 && n < 50);
        rd_chk(8'h08, 32'h00006050, 2'b00);
        rd_chk(8'h0C, 32'h40302010, 2'b00);
        chk("station", 48'h605040302010, station);
        $display("Test eeprom_load done");
        rx_chk(48'h605040302010, 1'b1);
        rx_chk(48'h605040302012, 1'b0);
        for (int i = 0; i < 4096; i++) begin
            if (hidx({24'h0, 16'(i), 8'h01}) == 6'h00) cand[0] = {24'h0, 16'(i), 8'h01};
            if (hidx({24'h0, 16'(i), 8'h01}) == 6'h3F) cand[1] = {24'h0, 16'(i), 8'h01};
        end
        for (int j = 0; j < 3; j++) begin
            one = 64'h1 << hidx(cand[j]);
            wr_chk(8'h10, one[63:32], 4'hF, 2'b00);
            wr_chk(8'h14, one[31:0], 4'hF, 2'b00);
            rx_chk(cand[j], 1'b1);
            wr_chk(8'h10, ~one[63:32], 4'hF, 2'b00);
            wr_chk(8'h14, ~one[31:0], 4'hF, 2'b00);
            rx_chk(cand[j], 1'b0);
        end
        wr_chk(8'h24, 32'h00000001, 4'hF, 2'b00);
        rx_chk(cand[2], 1'b1);
        $display("Test hash_filter done");
        summarize();
    end
endmodule : tb
`default_nettype wire
